// [arb_pkg.sv]
// constants, field layout, state codes and timing for the locality arbiter
// assumes a 50 MHz system clock and one host access port shared by localities
package arb_pkg;

  // ************************************************
  // localities
  // ************************************************
  localparam int NUM_LOC = 5;
  localparam int LOC_W = 3;
  localparam logic [LOC_W-1:0] LOC_LAST = 3'h4;

  // ************************************************
  // access register field positions
  // ************************************************
  localparam int BIT_VALID = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_OWNER = 5;
  localparam int BIT_TAKEN = 4;
  localparam int BIT_TAKEOVER = 3;
  localparam int BIT_WAITING = 2;
  localparam int BIT_REQUEST = 1;
  localparam int BIT_LAUNCH = 0;
  localparam logic LAUNCH_RESET = 1'b1;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_MHZ = 50;
  localparam int VALID_TIME_NS = 1000;
  // longest time, so round down, never below one cycle
  localparam int VALID_CYCLES_RAW = (VALID_TIME_NS * CLK_MHZ) / 1000;
  localparam int VALID_CYCLES = (VALID_CYCLES_RAW < 1) ? 1 : VALID_CYCLES_RAW;
  localparam int CNT_W = 12;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01
  } arb_state_type;

  // one-hot mask for a locality, zero when out of range
  function automatic logic [NUM_LOC-1:0] loc_bit(input logic [LOC_W-1:0] l);
    logic [NUM_LOC-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_LOC; i++) begin
      if (l == i[LOC_W-1:0]) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : loc_bit

endpackage : arb_pkg

// [pick_if.sv]
// carrier between the arbiter and its priority picker
// assumes arb_pkg is compiled first
`timescale 1ns/10ps
`default_nettype none
interface pick_if;
  import arb_pkg::*;
  logic [NUM_LOC-1:0] req;
  logic any;
  logic [LOC_W-1:0] idx;
  logic [NUM_LOC-1:0] rest;
  modport src (output req, input any, input idx, input rest);
  modport pick (input req, output any, output idx, output rest);
endinterface : pick_if
`default_nettype wire

// [highest_pick.sv]
// priority picker: highest numbered requester wins
// assumes a purely combinational use inside one clock domain
`timescale 1ns/10ps
`default_nettype none
module highest_pick (
  pick_if.pick p
);
  import arb_pkg::*;

  // ************************************************
  // scan upward so the last hit is the highest locality
  // ************************************************
  always_comb begin
    p.any = 1'b0;
    p.idx = '0;
    for (int i = 0; i < NUM_LOC; i++) begin
      if (p.req[i]) begin
        p.any = 1'b1;
        p.idx = i[LOC_W-1:0];
      end
    end
    p.rest = p.req & ~loc_bit(p.idx);
  end

endmodule : highest_pick
`default_nettype wire

// [locality_ownership_arbiter.sv]
// locality ownership arbiter with one access register per locality
// assumes the host holds a request until o_acc_done, one at a time,
// and that the command engine honours o_cmd_abort as an abort
`timescale 1ns/10ps
`default_nettype none
module locality_ownership_arbiter #(
  parameter int VALID_DELAY = arb_pkg::VALID_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic [arb_pkg::LOC_W-1:0] i_acc_locality,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_launch_flag,
  output logic o_acc_wait,
  output logic o_acc_done,
  output logic [7:0] o_acc_rdata,
  output logic o_owner_valid,
  output logic [arb_pkg::LOC_W-1:0] o_owner_locality,
  output logic o_cmd_abort
);
  import arb_pkg::*;

  // ************************************************
  // state
  // ************************************************
  arb_state_type state_r;
  logic [CNT_W-1:0] init_cnt_r;
  logic grant_pend_r;
  logic [NUM_LOC-1:0] req_r;
  logic [NUM_LOC-1:0] req_nxt;
  logic [NUM_LOC-1:0] wait_r;
  logic [NUM_LOC-1:0] wait_nxt;
  logic [NUM_LOC-1:0] seized_r;
  logic [NUM_LOC-1:0] seized_nxt;
  logic owner_valid_nxt;
  logic [LOC_W-1:0] owner_nxt;
  logic pend_nxt;
  logic launch_r;

  // decoded access
  logic run;
  logic accept;
  logic loc_ok;
  logic [NUM_LOC-1:0] sel;
  logic wr;
  logic is_own;
  logic seize_ok;
  logic relinq;
  logic cancel;
  logic reqset;
  logic clr_taken;
  logic grant;
  logic [7:0] rd_word;

  pick_if pk ();

  // ************************************************
  // helpers
  // ************************************************
  // true when any locality of the mask has its bit set in the vector;
  // used for per-locality reads of the request, wait and taken flags
  function automatic logic holds(input logic [NUM_LOC-1:0] v,
    input logic [NUM_LOC-1:0] m);
    return ((v & m) != '0);
  endfunction : holds

  // ************************************************
  // priority picker on the stored requests
  // ************************************************
  assign pk.req = req_r;

  highest_pick u_pick (
    .p(pk)
  );

  // ************************************************
  // access decode
  // ************************************************
  // an access waits while a grant is still in flight, so every field
  // seen by a read is settled when the answer leaves
  always_comb begin
    run = (state_r == ST_RUN);
    accept = i_acc_valid & ~o_acc_done & ~grant_pend_r;
    loc_ok = (i_acc_locality <= LOC_LAST);
    sel = loc_bit(i_acc_locality);
    wr = accept & i_acc_write & loc_ok & run;
    is_own = o_owner_valid & (o_owner_locality == i_acc_locality);
    // lowest locality can never be above an owner, so only a free
    // device lets it take over
    seize_ok = wr & i_acc_wdata[BIT_TAKEOVER] &
      (~o_owner_valid | (i_acc_locality > o_owner_locality));
    // (same term)
    relinq = wr & i_acc_wdata[BIT_OWNER] & is_own & ~seize_ok;
    cancel = wr & i_acc_wdata[BIT_OWNER] & ~is_own &
      holds(req_r, sel) & ~seize_ok;
    // owner write from an idle non-owner falls through all terms
    reqset = wr & i_acc_wdata[BIT_REQUEST] & ~holds(req_r, sel) &
      ~is_own & ~seize_ok & ~cancel;
    clr_taken = wr & i_acc_wdata[BIT_TAKEN];
    grant = grant_pend_r & ~o_owner_valid & pk.any;
  end

  // ************************************************
  // request flags
  // ************************************************
  // a write of 0 to the request bit has no term here at all
  always_comb begin
    req_nxt = req_r;
    if (seize_ok | cancel) begin
      // only the writer loses its request on takeover
      req_nxt = req_r & ~sel;
    end else if (reqset) begin
      req_nxt = req_r | sel;
    end else if (grant) begin
      req_nxt = pk.rest;
    end
  end

  // ************************************************
  // other-waiting flags follow the requests of the others
  // ************************************************
  // one expression covers set on request, clear on grant and the
  // cancel and takeover cases; software has no write path to these bits
  always_comb begin
    for (int i = 0; i < NUM_LOC; i++) begin
      wait_nxt[i] = holds(req_nxt, ~loc_bit(i[LOC_W-1:0]));
    end
  end

  // ************************************************
  // owner and taken-away flags
  // ************************************************
  always_comb begin
    owner_valid_nxt = o_owner_valid;
    owner_nxt = o_owner_locality;
    seized_nxt = seized_r;
    if (clr_taken) begin
      seized_nxt = seized_r & ~sel;
    end
    if (seize_ok) begin
      owner_valid_nxt = 1'b1;
      owner_nxt = i_acc_locality;
      if (o_owner_valid) begin
        // set is applied last so it wins over a clear
        seized_nxt = seized_nxt | loc_bit(o_owner_locality);
      end
    end else if (relinq) begin
      owner_valid_nxt = 1'b0;
    end else if (grant) begin
      owner_valid_nxt = 1'b1;
      owner_nxt = pk.idx;
    end
  end

  // ************************************************
  // grant scheduling
  // ************************************************
  // a grant is taken one cycle after the event that frees the device,
  // far inside any grant timeout; the extra cycle keeps decode short
  always_comb begin
    pend_nxt = 1'b0;
    if (relinq) begin
      pend_nxt = 1'b1;
    end else if (reqset & ~o_owner_valid) begin
      pend_nxt = 1'b1;
    end
  end

  // ************************************************
  // read word
  // ************************************************
  always_comb begin
    rd_word = 8'h00;
    if (loc_ok) begin
      rd_word[BIT_VALID] = run;
      rd_word[BIT_RSVD] = 1'b0;
      rd_word[BIT_OWNER] = is_own;
      rd_word[BIT_TAKEN] = holds(seized_r, sel);
      rd_word[BIT_TAKEOVER] = 1'b0;
      rd_word[BIT_WAITING] = holds(wait_r, sel);
      rd_word[BIT_REQUEST] = holds(req_r, sel);
      rd_word[BIT_LAUNCH] = launch_r;
    end
    if (!run) begin
      // before the flag is set the other fields read as zero
      rd_word = 8'h00;
    end
  end

  // ************************************************
  // reset settle counter
  // ************************************************
  // counts the settle time and freezes once it is spent, so the
  // compare below never sees a wrapped count
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      init_cnt_r <= '0;
    end else if ((state_r == ST_INIT) &&
      (init_cnt_r != CNT_W'(VALID_DELAY - 1))) begin
      init_cnt_r <= init_cnt_r + 1'b1;
    end
  end

  // the flag rises once the count is spent and stays up until reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r <= ST_INIT;
    end else begin
      case (state_r)
        ST_INIT: begin
          if (init_cnt_r == CNT_W'(VALID_DELAY - 1)) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

  // ************************************************
  // arbitration registers, one block per concern
  // ************************************************
  // stored requests, one bit per locality; only cancel, takeover and
  // grant ever clear a bit here
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // other-waiting flags, registered with the requests they follow
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wait_r <= '0;
    end else begin
      wait_r <= wait_nxt;
    end
  end

  // taken-away flags; each stays set until its own locality clears it,
  // so a moved-out owner learns of it on its next read
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      seized_r <= '0;
    end else begin
      seized_r <= seized_nxt;
    end
  end

  // owner of the device; the locality is kept while nobody owns
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_owner_valid <= 1'b0;
      o_owner_locality <= '0;
    end else begin
      o_owner_valid <= owner_valid_nxt;
      o_owner_locality <= owner_nxt;
    end
  end

  // a grant waits one cycle behind the event that frees the device,
  // which always falls in the done cycle of that event's access
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      grant_pend_r <= 1'b0;
    end else begin
      grant_pend_r <= pend_nxt;
    end
  end

  // ************************************************
  // command abort pulse
  // ************************************************
  // the pulse lands with the takeover's answer, so the command engine
  // drops the old owner's command before the new owner can send one
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cmd_abort <= 1'b0;
    end else begin
      o_cmd_abort <= seize_ok;
    end
  end

  // ************************************************
  // launch flag mirror
  // ************************************************
  // the flag itself lives elsewhere; only its current value shows here
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      launch_r <= LAUNCH_RESET;
    end else begin
      launch_r <= i_launch_flag;
    end
  end

  // ************************************************
  // host answer
  // ************************************************
  // done pulses once for each access taken
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_acc_done <= 1'b0;
    end else begin
      o_acc_done <= accept;
    end
  end

  // stall shown while a held request is not yet taken; a grant only
  // pends in a done cycle, which is never taken, so this stays low
  // unless that spacing changes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_acc_wait <= 1'b0;
    end else begin
      o_acc_wait <= i_acc_valid & ~o_acc_done & grant_pend_r;
    end
  end

  // read word captured as the access is taken, zero after a write
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_acc_rdata <= 8'h00;
    end else if (accept & ~i_acc_write) begin
      o_acc_rdata <= rd_word;
    end else if (accept) begin
      o_acc_rdata <= 8'h00;
    end
  end

endmodule : locality_ownership_arbiter
`default_nettype wire

// [arb_chk.sv]
// checker: timing and field assertions on the arbiter's top ports
// assumes a bind onto locality_ownership_arbiter, one clock domain
`timescale 1ns/10ps
`default_nettype none
module arb_chk #(
  parameter int VALID_DELAY = arb_pkg::VALID_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic [arb_pkg::LOC_W-1:0] i_acc_locality,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_launch_flag,
  input wire logic o_acc_wait,
  input wire logic o_acc_done,
  input wire logic [7:0] o_acc_rdata,
  input wire logic o_owner_valid,
  input wire logic [arb_pkg::LOC_W-1:0] o_owner_locality,
  input wire logic o_cmd_abort
);
  import arb_pkg::*;
  logic [7:0] up_cnt_r;
  logic up;
  // ************************************************
  // helper and properties
  // ************************************************
  // cycles since release, saturating so it never wraps
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      up_cnt_r <= 8'h00;
    end else if (up_cnt_r != 8'hFF) begin
      up_cnt_r <= up_cnt_r + 8'h01;
    end
  end
  // margin of three: the read word is taken a cycle before done
  assign up = (int'(up_cnt_r) >= VALID_DELAY + 3);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_take(logic [7:0] wd);
    i_acc_valid && i_acc_write && !o_acc_done && i_acc_wdata == wd && up
      && i_acc_locality <= LOC_LAST ##1 o_acc_done;
  endsequence
  property p_answer;
    $rose(i_acc_valid) |-> ##[1:3] o_acc_done;
  endproperty
  property p_stall;
    o_acc_wait |=> o_acc_done;
  endproperty
  property p_pulse;
    o_acc_done |=> !o_acc_done;
  endproperty
  property p_fixed;
    o_acc_done |-> !o_acc_rdata[BIT_RSVD] && !o_acc_rdata[BIT_TAKEOVER];
  endproperty
  property p_invalid;
    o_acc_done && !o_acc_rdata[BIT_VALID] |-> o_acc_rdata == 8'h00;
  endproperty
  property p_valid_up;
    o_acc_done && !$past(i_acc_write) && $past(i_acc_locality) <= LOC_LAST
      && up |-> o_acc_rdata[BIT_VALID];
  endproperty
  property p_owner;
    o_acc_done && !$past(i_acc_write) && o_acc_rdata[BIT_VALID] |->
      o_acc_rdata[BIT_OWNER] == (o_owner_valid
      && o_owner_locality == $past(i_acc_locality));
  endproperty
  property p_abort;
    o_cmd_abort |-> o_acc_done && $past(i_acc_wdata[BIT_TAKEOVER])
      && o_owner_locality == $past(i_acc_locality);
  endproperty
  property p_abort_one;
    o_cmd_abort |=> !o_cmd_abort;
  endproperty
  property p_rel;
    (o_owner_valid && o_owner_locality == i_acc_locality ##0 s_take(8'h20))
      |-> !o_owner_valid;
  endproperty
  property p_grant;
    (!o_owner_valid ##0 s_take(8'h02)) |=> o_owner_valid
      && o_owner_locality == $past(i_acc_locality, 2);
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_pulse: assert property (p_pulse) else $error("done too long");
  a_stall: assert property (p_stall) else $error("stall not ended");
  a_fixed: assert property (p_fixed) else $error("fixed bit set");
  a_invalid: assert property (p_invalid) else $error("unsettled word");
  a_valid_up: assert property (p_valid_up) else $error("valid late");
  a_owner: assert property (p_owner) else $error("owner bit wrong");
  a_abort: assert property (p_abort) else $error("bad abort");
  a_abort_one: assert property (p_abort_one) else $error("abort long");
  a_rel: assert property (p_rel) else $error("still owned");
  a_grant: assert property (p_grant) else $error("no grant");
endmodule : arb_chk
bind locality_ownership_arbiter arb_chk #(.VALID_DELAY(VALID_DELAY)) chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_acc_valid(i_acc_valid),
  .i_acc_write(i_acc_write), .i_acc_locality(i_acc_locality),
  .i_acc_wdata(i_acc_wdata), .i_launch_flag(i_launch_flag),
  .o_acc_wait(o_acc_wait), .o_acc_done(o_acc_done),
  .o_acc_rdata(o_acc_rdata), .o_owner_valid(o_owner_valid),
  .o_owner_locality(o_owner_locality), .o_cmd_abort(o_cmd_abort));
`default_nettype wire

// [host_bfm.sv]
// host software model: one access at a time to any locality's register
// assumes the caller starts each access right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module host_bfm (
  input wire logic i_sys_clk,
  input wire logic i_acc_done,
  input wire logic [7:0] i_acc_rdata,
  output logic o_acc_valid,
  output logic o_acc_write,
  output logic [arb_pkg::LOC_W-1:0] o_acc_locality,
  output logic [7:0] o_acc_wdata
);
  import arb_pkg::*;
  // idle levels before the first access
  initial begin
    o_acc_valid = 1'b0;
    o_acc_write = 1'b0;
    o_acc_locality = '0;
    o_acc_wdata = 8'h00;
  end
  // ************************************************
  // access task
  // ************************************************
  // held until done seen; a hang returns unknown data to fail compares
  task automatic acc(input logic w, input logic [LOC_W-1:0] l,
    input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    r = 8'hXX;
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b1;
    o_acc_write <= w;
    o_acc_locality <= l;
    o_acc_wdata <= d;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (i_acc_done !== 1'b1 && n < 16);
    if (i_acc_done === 1'b1) begin
      r = i_acc_rdata;
    end
    @(posedge i_sys_clk);
    o_acc_valid <= 1'b0;
    o_acc_wdata <= ~d; // released data is not left looking valid
  endtask : acc
endmodule : host_bfm
`default_nettype wire

// [tb_top.sv]
// testbench: locality ownership sequences through the host model
// assumes arb_pkg, pick_if, highest_pick and the arbiter are compiled
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import arb_pkg::*;
  localparam int VD = 4;
  localparam logic [7:0] V = 8'h81; // valid plus launch mirror at 1
  logic clk, rst, valid, write, done, wt, ov, abort;
  logic [LOC_W-1:0] loc, oloc;
  logic [7:0] wdata, rdata;
  int errors, tests_run, aborts;
  locality_ownership_arbiter #(.VALID_DELAY(VD)) uut (.i_sys_clk(clk),
    .i_rst(rst), .i_acc_valid(valid), .i_acc_write(write),
    .i_acc_locality(loc), .i_acc_wdata(wdata), .i_launch_flag(1'b1),
    .o_acc_wait(wt), .o_acc_done(done), .o_acc_rdata(rdata),
    .o_owner_valid(ov), .o_owner_locality(oloc), .o_cmd_abort(abort));
  host_bfm host (.i_sys_clk(clk), .i_acc_done(done), .i_acc_rdata(rdata),
    .o_acc_valid(valid), .o_acc_write(write), .o_acc_locality(loc),
    .o_acc_wdata(wdata));
  // ************************************************
  // tasks
  // ************************************************
  task automatic eq(input logic ok);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t owner or abort state wrong", $time);
    end
  endtask : eq
  task automatic rd(input logic [LOC_W-1:0] l, input logic [7:0] e);
    logic [7:0] r;
    host.acc(1'b0, l, 8'h00, r);
    tests_run++;
    if (r !== e) begin
      errors++;
      $display("[ERR] %0t loc %0d read %h not %h", $time, l, r, e);
    end
  endtask : rd
  task automatic wr(input logic [LOC_W-1:0] l, input logic [7:0] d);
    logic [7:0] r;
    host.acc(1'b1, l, d, r);
    @(negedge clk); // let the edge's updates land before any check
    tests_run++;
    if (r !== 8'h00) begin
      errors++;
      $display("[ERR] %0t loc %0d write not answered", $time, l);
    end
  endtask : wr
  task automatic results;
    $display("errors %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // ************************************************
  // clock, monitor, watchdog, sequence
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // abort pulses counted so each takeover shows exactly once
  always @(posedge clk) begin
    if (abort === 1'b1) begin
      aborts <= aborts + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    rst = 1'b1;
    {errors, tests_run, aborts} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(3'h0, 8'h00);
    repeat (VD) @(posedge clk);
    rd(3'h0, V);
    wr(3'h1, 8'h44);
    rd(3'h1, V);
    wr(3'h1, 8'h02);
    rd(3'h1, V | 8'h20);
    wr(3'h0, 8'h02);
    rd(3'h0, V | 8'h02);
    rd(3'h2, V | 8'h04);
    wr(3'h3, 8'h02);
    wr(3'h1, 8'h20);
    rd(3'h1, V | 8'h04);
    rd(3'h3, V | 8'h24);
    wr(3'h0, 8'h00);
    rd(3'h0, V | 8'h02);
    wr(3'h0, 8'h20);
    rd(3'h0, V);
    rd(3'h3, V | 8'h20);
    wr(3'h2, 8'h20);
    eq(ov && oloc === 3'h3);
    wr(3'h2, 8'h08);
    eq(oloc === 3'h3 && aborts == 0);
    wr(3'h0, 8'h02);
    wr(3'h4, 8'h08);
    eq(oloc === 3'h4 && aborts == 1);
    rd(3'h3, V | 8'h14);
    rd(3'h0, V | 8'h02);
    rd(3'h4, V | 8'h24);
    wr(3'h3, 8'h10);
    rd(3'h3, V | 8'h04);
    wr(3'h0, 8'h08);
    eq(oloc === 3'h4 && aborts == 1);
    wr(3'h0, 8'h20);
    wr(3'h4, 8'h20);
    eq(ov === 1'b0);
    wr(3'h0, 8'h08);
    eq(ov && oloc === 3'h0 && aborts == 2);
    rd(3'h5, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
